// [iex_pkg.sv]
// Package for the integer execute datapath: operation codes, flag layout,
// address modes and reset values.
// Assumes a decoder upstream that presents one operation per request.
package iex_pkg;

  // Operation selected by the decoder for one request.
  typedef enum logic [5:0] {
    IEX_COPY_IMM, IEX_COPY_REG, IEX_NOT, IEX_RSB, IEX_TEST,
    IEX_ASR_IMM, IEX_ASR_REG, IEX_LSL_IMM, IEX_LSL_REG,
    IEX_LSR_IMM, IEX_LSR_REG, IEX_ROR_REG, IEX_MUL,
    IEX_SIGN_EXTEND_BYTE_OP, IEX_SIGN_EXTEND_HALF_OP, IEX_ZERO_EXTEND_BYTE_OP, IEX_ZERO_EXTEND_HALF_OP,
    IEX_REV_W, IEX_REV_H, IEX_REV_SH,
    IEX_READ_STATUS, IEX_WRITE_STATUS,
    IEX_LOAD, IEX_STORE, IEX_LOAD_MANY, IEX_STORE_MANY,
    IEX_PUSH, IEX_POP,
    IEX_SUPERVISOR_CALL, IEX_BREAKPOINT, IEX_ILLEGAL
  } iex_op_e;

  // Access size for single loads and stores.
  typedef enum logic [1:0] {
    IEX_SZ_BYTE, IEX_SZ_HALF, IEX_SZ_WORD
  } iex_size_e;

  // Base register class for addressing.
  typedef enum logic [1:0] {
    IEX_BASE_LOW, IEX_BASE_STACK, IEX_BASE_PC
  } iex_base_e;

  // Transfer state of a single or multiple-word access.
  typedef enum logic [1:0] {
    IEX_IDLE, IEX_XFER, IEX_DONE
  } iex_state_e;

  // Flag positions within the four-bit flag nibble (N Z C V).
  localparam int IEX_FLAG_N = 3;
  localparam int IEX_FLAG_Z = 2;
  localparam int IEX_FLAG_C = 1;
  localparam int IEX_FLAG_V = 0;
  // Flag nibble sits in the top four bits of the status word.
  localparam int IEX_FLAG_POS = 28;
  localparam logic [3:0]  IEX_FLAGS_RESET = 4'h0;
  localparam logic [31:0] IEX_WORD_RESET  = 32'h0000_0000;
  localparam logic [4:0]  IEX_CNT_RESET   = 5'h00;
  // Bytes per word of a multiple transfer.
  localparam logic [31:0] IEX_WORD_BYTES  = 32'h0000_0004;
  // Copy immediate is limited to this width.
  localparam int IEX_IMM8_W = 8;
  // Literal base is the program counter with the low two bits forced low.
  localparam logic [31:0] IEX_PC_ALIGN = 32'hffff_fffc;

endpackage

// [iex_datapath.sv]
// Integer execute datapath: single-operation ALU, shifter, multiplier,
// extenders, flag register and a sequencer for single and multiple memory accesses.
// Assumes a decoder that holds req until ack and a memory answering mem_req with mem_ack.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Copy loads 8-bit immediate or register only.
// - NOT takes one register, no variants.
// - Reverse subtract with zero immediate negates.
// - Test ANDs, sets flags, no write.
// - Shifts both amount forms; rotate register only.
// - Multiply returns low 32 bits only.
// - Extend low byte or half to 32.
// - Status flags copied to or from register.
// - Narrow stores write low 16 or 8.
// - Narrow loads zero or sign extend.
// - Address is base plus offset, restricted bases.
// - Program counter base only for loads.
// - Immediate offset unsigned, added or subtracted.
// - Register offset never the program counter.
// - Multiples walk consecutive words, optional writeback.
// - Push pre-decrements and writes back base.
// - Popped program counter is an interworking branch.
// - Supervisor call raises supervisor exception.
// - Breakpoint halts if debug allows.
// - Without privilege option, always privileged.
// - Interworking address leaving compact state faults.
// - Untouched flags keep previous values.
module iex_datapath (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             req,
  input  wire iex_pkg::iex_op_e op,
  input  wire logic [31:0]      opa,
  input  wire logic [31:0]      opb,
  input  wire logic [7:0]       imm,
  input  wire logic [4:0]       shamt_imm,
  input  wire iex_pkg::iex_size_e size,
  input  wire logic             sign_load,
  input  wire iex_pkg::iex_base_e base_sel,
  input  wire logic             off_is_reg,
  input  wire logic             off_reg_is_pc,
  input  wire logic             off_sub,
  input  wire logic [4:0]       many_count,
  input  wire logic             many_down,
  input  wire logic             many_wb,
  input  wire logic             pop_loads_pc,
  input  wire logic             debug_enable,
  input  wire logic             priv_option,
  output logic                  ack,
  output logic [31:0]           result,
  output logic                  result_we,
  output logic [31:0]           base_out,
  output logic                  base_we,
  output logic [3:0]            flags,
  output logic                  privileged,
  output logic                  branch_valid,
  output logic [31:0]           branch_addr,
  output logic                  fault,
  output logic                  supervisor_exception,
  output logic                  halt,
  output logic                  illegal,
  output logic                  mem_req,
  output logic                  mem_write,
  output logic [31:0]           mem_addr,
  output logic [31:0]           mem_wdata,
  output logic [1:0]            mem_size,
  input  wire logic             mem_ack,
  input  wire logic [31:0]      mem_rdata
);
  import iex_pkg::*;

  // All state of the block.
  typedef struct packed {
    iex_state_e  state;
    logic        ack;
    logic [31:0] result;
    logic        result_we;
    logic [31:0] base_out;
    logic        base_we;
    logic [3:0]  flags;
    logic        branch_valid;
    logic [31:0] branch_addr;
    logic        fault;
    logic        supervisor_call;
    logic        halt;
    logic        illegal;
    logic        mem_req;
    logic        mem_write;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [1:0]  mem_size;
    logic [4:0]  left;
    logic [31:0] final_base;
  } iex_s;

  iex_s cur;
  iex_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational operation results.

  logic [31:0] alu;
  logic [3:0]  alu_flags;
  logic        alu_write;
  logic [32:0] sub_full;
  logic [7:0]  amt;
  logic [31:0] base_val;
  logic [31:0] offset;
  logic [31:0] eff_addr;
  logic [31:0] load_ext;
  logic [63:0] prod;
  logic [64:0] sh_l;
  logic [32:0] sh_r;
  logic [32:0] sh_a;
  logic [63:0] rot2;

  assign prod = opa * opb;
  assign sub_full = {1'b0, opb} - {1'b0, opa};

  // Register shift amounts use the low byte; immediate amounts are five bits.
  always_comb begin
    amt = {3'h0, shamt_imm};
    if (op == IEX_ASR_REG || op == IEX_LSL_REG || op == IEX_LSR_REG
        || op == IEX_ROR_REG) begin
      amt = opb[7:0];
    end
  end

  // Shifts keep a spare bit for the carry out; the shifter saturates past 32.
  assign sh_l = (amt > 8'd32) ? 65'h0 : ({33'h0, opa} << amt);
  assign sh_r = (amt > 8'd32) ? 33'h0 : ({opa, 1'b0} >> amt);
  assign sh_a = (amt > 8'd32) ? {33{opa[31]}} : 33'($signed({opa, 1'b0}) >>> amt);
  assign rot2 = {opa, opa} >> amt[4:0];

  // Result and flag update per operation; untouched flags carry over.
  always_comb begin
    alu       = IEX_WORD_RESET;
    alu_flags = cur.flags;
    alu_write = 1'b1;
    unique case (op)
      IEX_COPY_IMM: alu = {24'h0, imm[IEX_IMM8_W-1:0]};
      IEX_COPY_REG: alu = opa;
      IEX_NOT:      alu = ~opa;
      IEX_RSB: begin
        alu = sub_full[31:0];
        alu_flags[IEX_FLAG_C] = ~sub_full[32];
        alu_flags[IEX_FLAG_V] = (opb[31] ^ opa[31]) & (opb[31] ^ sub_full[31]);
      end
      IEX_TEST: begin
        alu = opa & opb;
        alu_write = 1'b0;
      end
      IEX_LSL_IMM, IEX_LSL_REG: begin
        alu = sh_l[31:0];
        if (amt != 8'h00) alu_flags[IEX_FLAG_C] = sh_l[32];
      end
      IEX_LSR_IMM, IEX_LSR_REG: begin
        alu = sh_r[32:1];
        if (amt != 8'h00) alu_flags[IEX_FLAG_C] = sh_r[0];
      end
      IEX_ASR_IMM, IEX_ASR_REG: begin
        alu = sh_a[32:1];
        if (amt != 8'h00) alu_flags[IEX_FLAG_C] = sh_a[0];
      end
      IEX_ROR_REG: begin
        alu = rot2[31:0];
        if (amt != 8'h00) alu_flags[IEX_FLAG_C] = rot2[31];
      end
      IEX_MUL:     alu = prod[31:0];
      IEX_SIGN_EXTEND_BYTE_OP: alu = {{24{opa[7]}}, opa[7:0]};
      IEX_SIGN_EXTEND_HALF_OP: alu = {{16{opa[15]}}, opa[15:0]};
      IEX_ZERO_EXTEND_BYTE_OP: alu = {24'h0, opa[7:0]};
      IEX_ZERO_EXTEND_HALF_OP: alu = {16'h0, opa[15:0]};
      IEX_REV_W:   alu = {opa[7:0], opa[15:8], opa[23:16], opa[31:24]};
      IEX_REV_H:   alu = {opa[23:16], opa[31:24], opa[7:0], opa[15:8]};
      IEX_REV_SH:  alu = {{16{opa[7]}}, opa[7:0], opa[15:8]};
      IEX_READ_STATUS: alu = {cur.flags, 28'h0};
      default: alu_write = 1'b0;
    endcase
    // Data operations other than the status transfers and register copy set N and Z.
    if (op != IEX_READ_STATUS && op != IEX_WRITE_STATUS && alu_write | (op == IEX_TEST)
        && op != IEX_COPY_REG) begin
      alu_flags[IEX_FLAG_N] = alu[31];
      alu_flags[IEX_FLAG_Z] = (alu == IEX_WORD_RESET);
    end
    if (op == IEX_WRITE_STATUS) alu_flags = opa[IEX_FLAG_POS+3:IEX_FLAG_POS];
  end

  // Base selection; literal loads see a word-aligned program counter.
  always_comb begin
    unique case (base_sel)
      IEX_BASE_PC: base_val = opa & IEX_PC_ALIGN;
      default:     base_val = opa;
    endcase
    offset   = off_is_reg ? opb : {24'h0, imm};
    eff_addr = off_sub ? base_val - offset : base_val + offset;
  end

  // Narrow loads extend according to the signed selector.
  always_comb begin
    unique case (size)
      IEX_SZ_BYTE: load_ext = sign_load ? {{24{mem_rdata[7]}}, mem_rdata[7:0]}
                                        : {24'h0, mem_rdata[7:0]};
      IEX_SZ_HALF: load_ext = sign_load ? {{16{mem_rdata[15]}}, mem_rdata[15:0]}
                                        : {16'h0, mem_rdata[15:0]};
      default:     load_ext = mem_rdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. A request is taken in IDLE; pulses last one cycle.

  logic [31:0] span;
  assign span = {25'h0, many_count, 2'b00};

  always_comb begin
    next_cur              = cur;
    next_cur.ack          = 1'b0;
    next_cur.result_we    = 1'b0;
    next_cur.base_we      = 1'b0;
    next_cur.branch_valid = 1'b0;
    next_cur.fault        = 1'b0;
    next_cur.supervisor_call          = 1'b0;
    next_cur.halt         = 1'b0;
    next_cur.illegal      = 1'b0;
    unique case (cur.state)
      IEX_IDLE: begin
        if (req) begin
          unique case (op)
            IEX_LOAD, IEX_STORE: begin
              if ((op == IEX_STORE && base_sel == IEX_BASE_PC)
                  || (off_is_reg && off_reg_is_pc)) begin
                next_cur.illegal = 1'b1;
                next_cur.ack     = 1'b1;
              end else begin
                next_cur.mem_req   = 1'b1;
                next_cur.mem_write = (op == IEX_STORE);
                next_cur.mem_addr  = eff_addr;
                next_cur.mem_size  = size;
                // Upper lanes zeroed so a narrow store carries the low bits only.
                unique case (size)
                  IEX_SZ_BYTE: next_cur.mem_wdata = {24'h0, opb[7:0]};
                  IEX_SZ_HALF: next_cur.mem_wdata = {16'h0, opb[15:0]};
                  default:     next_cur.mem_wdata = opb;
                endcase
                next_cur.left  = 5'h01;
                next_cur.state = IEX_XFER;
              end
            end
            IEX_LOAD_MANY, IEX_STORE_MANY, IEX_PUSH, IEX_POP: begin
              next_cur.mem_req   = (many_count != IEX_CNT_RESET);
              next_cur.mem_write = (op == IEX_STORE_MANY || op == IEX_PUSH);
              next_cur.mem_size  = IEX_SZ_WORD;
              next_cur.mem_wdata = opb;
              next_cur.left      = many_count;
              // Push and descending walks start below the base.
              if (op == IEX_PUSH || (many_down && op != IEX_POP)) begin
                next_cur.mem_addr   = opa - span;
                next_cur.final_base = opa - span;
              end else begin
                next_cur.mem_addr   = opa;
                next_cur.final_base = opa + span;
              end
              next_cur.state = (many_count != IEX_CNT_RESET) ? IEX_XFER : IEX_DONE;
            end
            IEX_SUPERVISOR_CALL: begin
              next_cur.supervisor_call = 1'b1;
              next_cur.ack = 1'b1;
            end
            IEX_BREAKPOINT: begin
              next_cur.halt = debug_enable;
              next_cur.ack  = 1'b1;
            end
            IEX_ILLEGAL: begin
              next_cur.illegal = 1'b1;
              next_cur.ack     = 1'b1;
            end
            default: begin
              if (alu_write) next_cur.result = alu;
              next_cur.result_we = alu_write;
              next_cur.flags     = alu_flags;
              next_cur.ack       = 1'b1;
            end
          endcase
        end
      end
      IEX_XFER: begin
        if (mem_ack) begin
          next_cur.left = cur.left - 5'h01;
          if (!cur.mem_write) begin
            next_cur.result    = load_ext;
            next_cur.result_we = 1'b1;
          end
          next_cur.mem_addr = cur.mem_addr + IEX_WORD_BYTES;
          if (cur.left == 5'h01) begin
            next_cur.mem_req = 1'b0;
            next_cur.state   = IEX_DONE;
            if (op == IEX_POP && pop_loads_pc) begin
              next_cur.result_we   = 1'b0;
              next_cur.branch_addr = {mem_rdata[31:1], 1'b0};
              next_cur.branch_valid = mem_rdata[0];
              next_cur.fault       = ~mem_rdata[0];
            end
          end else begin
            next_cur.mem_wdata = opb;
          end
        end
      end
      IEX_DONE: begin
        next_cur.ack = 1'b1;
        if (op == IEX_PUSH || op == IEX_POP
            || ((op == IEX_LOAD_MANY || op == IEX_STORE_MANY) && many_wb)) begin
          next_cur.base_out = cur.final_base;
          next_cur.base_we  = 1'b1;
        end
        next_cur.state = IEX_IDLE;
      end
      default: next_cur.state = IEX_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur       <= '0;
      cur.state <= IEX_IDLE;
      cur.flags <= IEX_FLAGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign ack                  = cur.ack;
  assign result               = cur.result;
  assign result_we            = cur.result_we;
  assign base_out             = cur.base_out;
  assign base_we              = cur.base_we;
  assign flags                = cur.flags;
  assign privileged           = 1'b1 | priv_option;
  assign branch_valid         = cur.branch_valid;
  assign branch_addr          = cur.branch_addr;
  assign fault                = cur.fault;
  assign supervisor_exception = cur.supervisor_call;
  assign halt                 = cur.halt;
  assign illegal              = cur.illegal;
  assign mem_req              = cur.mem_req;
  assign mem_write            = cur.mem_write;
  assign mem_addr             = cur.mem_addr;
  assign mem_wdata            = cur.mem_wdata;
  assign mem_size             = cur.mem_size;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence neg_taken_s;
    req && cur.state == IEX_IDLE && op == IEX_RSB;
  endsequence

  neg_result_a: assert property (@(posedge clock) disable iff (!rst_b)
    neg_taken_s |=> result == 32'($past(opb) - $past(opa)))
    else $error("Reverse subtract result wrong.");

  test_nowrite_a: assert property (@(posedge clock) disable iff (!rst_b)
    (req && cur.state == IEX_IDLE && op == IEX_TEST) |=> !result_we && ack)
    else $error("Test wrote a result.");

  mul_low_a: assert property (@(posedge clock) disable iff (!rst_b)
    (req && cur.state == IEX_IDLE && op == IEX_MUL) |=> result == 32'($past(opa) * $past(opb)))
    else $error("Multiply low word wrong.");

  svc_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
    (req && cur.state == IEX_IDLE && op == IEX_SUPERVISOR_CALL) |=> supervisor_exception)
    else $error("Supervisor exception missing.");

  halt_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    halt |-> $past(debug_enable))
    else $error("Halt without debug enable.");

  priv_always_a: assert property (@(posedge clock) disable iff (!rst_b)
    privileged)
    else $error("Execution left privileged level.");

  pop_fault_a: assert property (@(posedge clock) disable iff (!rst_b)
    fault |-> !branch_valid ##1 ack)
    else $error("Fault and branch together.");

  flags_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cur.state == IEX_IDLE && !(req && op == IEX_WRITE_STATUS)) && !req |=> $stable(flags))
    else $error("Flags changed with no operation.");

  push_base_a: assert property (@(posedge clock) disable iff (!rst_b)
    (req && cur.state == IEX_IDLE && op == IEX_PUSH) |=> mem_addr == $past(opa) - $past(span))
    else $error("Push did not pre-decrement.");

endmodule

`default_nettype wire

// [iex_mem_model.sv]
// Memory model that answers the datapath's word, halfword and byte accesses.
// Assumes one clock, a synchronous active-low reset, and mem_req held until mem_ack.
`timescale 1ns/1ps
`default_nettype none
module iex_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [1:0]  delay,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] store [logic [31:0]];
  logic [1:0]  wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Words never written read as their address XORed with a fixed pattern.
  function automatic logic [31:0] peek(input logic [31:0] a);
    return store.exists(a) ? store[a] : a ^ 32'hc3a5_0011;
  endfunction

  // Answers after the chosen wait; read data is scrambled outside the answer cycle,
  // so a design that samples it late cannot pass by luck.
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_b) begin
      wait_cnt <= 2'h0;
      mem_rdata <= 32'ha5a5_5a5a;
    end else if (mem_req && !mem_ack) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt >= delay) begin
        mem_ack <= 1'b1;
        wait_cnt <= 2'h0;
        mem_rdata <= peek(mem_addr);
        if (mem_write) begin
          store[mem_addr] = mem_wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the integer execute datapath.
// Assumes the package, the datapath and the memory model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iex_pkg::*;
  typedef struct {logic [31:0] res; logic rchk; logic [3:0] flg; logic [3:0] fm;
                  logic [31:0] base; logic [4:0] ev; logic [31:0] br;} iex_note_s;
  typedef struct {logic [31:0] addr; logic [31:0] wd; logic wr; logic [1:0] sz;} iex_acc_s;
  logic        clock, rst_b, req, sign_load, off_is_reg, off_reg_is_pc, off_sub;
  logic        many_down, many_wb, pop_loads_pc, debug_enable, priv_option;
  logic        ack, result_we, base_we, privileged, branch_valid, fault;
  logic        supervisor_exception, halt, illegal, mem_req, mem_write, mem_ack;
  logic [31:0] opa, opb, result, base_out, branch_addr, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] seed, cur_base, cur_res, br_seen, d, r, c, w;
  logic [7:0]  imm;
  logic [4:0]  shamt_imm, many_count, ev_seen, ev;
  logic [1:0]  mem_size, delay;
  iex_op_e     op, o;
  iex_size_e   size;
  iex_base_e   base_sel;
  int          err_total, check_count;
  iex_note_s   note_q[$];
  iex_acc_s    acc_q[$];
  iex_acc_s    acc;
  iex_note_s   n, got;

  iex_datapath dut (.clock, .rst_b, .req, .op, .opa, .opb, .imm, .shamt_imm, .size,
    .sign_load, .base_sel, .off_is_reg, .off_reg_is_pc, .off_sub, .many_count,
    .many_down, .many_wb, .pop_loads_pc, .debug_enable, .priv_option, .ack, .result,
    .result_we, .base_out, .base_we, .flags(), .privileged, .branch_valid, .branch_addr,
    .fault, .supervisor_exception, .halt, .illegal, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .mem_size, .mem_ack, .mem_rdata);
  iex_mem_model mem (.clock, .rst_b, .delay, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .mem_size, .mem_ack, .mem_rdata);

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ext(logic [31:0] v, iex_size_e z, logic s);
    if (z == IEX_SZ_BYTE) return s ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
    if (z == IEX_SZ_HALF) return s ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
    return v;
  endfunction

  function automatic logic [31:0] alu(iex_op_e q, logic [31:0] a, b, logic [7:0] i,
                                      logic [4:0] s);
    case (q)
      IEX_COPY_IMM: return {24'h0, i};
      IEX_COPY_REG: return a;
      IEX_NOT:      return ~a;
      IEX_RSB:      return 32'h0 - a;
      IEX_ASR_IMM:  return $signed(a) >>> s;
      IEX_ASR_REG:  return $signed(a) >>> b[4:0];
      IEX_LSL_IMM:  return a << s;
      IEX_LSL_REG:  return a << b[4:0];
      IEX_LSR_IMM:  return a >> s;
      IEX_LSR_REG:  return a >> b[4:0];
      IEX_ROR_REG:  return (a >> b[4:0]) | (a << (6'd32 - {1'b0, b[4:0]}));
      IEX_MUL:      return a * b;
      IEX_SIGN_EXTEND_BYTE_OP:  return ext(a, IEX_SZ_BYTE, 1'b1);
      IEX_SIGN_EXTEND_HALF_OP:  return ext(a, IEX_SZ_HALF, 1'b1);
      IEX_ZERO_EXTEND_BYTE_OP:  return ext(a, IEX_SZ_BYTE, 1'b0);
      IEX_ZERO_EXTEND_HALF_OP:  return ext(a, IEX_SZ_HALF, 1'b0);
      IEX_REV_W:    return {a[7:0], a[15:8], a[23:16], a[31:24]};
      IEX_REV_H:    return {a[23:16], a[31:24], a[7:0], a[15:8]};
      IEX_REV_SH:   return {{16{a[7]}}, a[7:0], a[15:8]};
      default:      return a & b;
    endcase
  endfunction

  function automatic iex_note_s nt(logic [31:0] v, logic rc, logic [3:0] f, fm,
                                   logic [4:0] e);
    return '{v, rc, f, fm, cur_base, e, 32'h0};
  endfunction

  task automatic check(input logic [31:0] seen, exp, input string m);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // One request held until its answer; the note goes to the watcher first.
  task automatic go(input iex_op_e q, input iex_note_s e);
    int t;
    @(negedge clock);
    delay = 2'(xs());
    priv_option = 1'(xs());
    op = q;
    req = 1'b1;
    note_q.push_back(e);
    t = 0;
    do begin
      @(negedge clock);
      t++;
    end while (ack !== 1'b1 && t < 300);
    if (t >= 300) check(32'h0, 32'h1, "no answer");
    req = 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Pulses are gathered between answers, since they may lead the answer by cycles.
  always @(posedge clock) begin
    if (!rst_b) begin
      ev_seen <= 5'h0;
    end else begin
      ev = ev_seen | {branch_valid, fault, supervisor_exception, halt, illegal};
      if (branch_valid === 1'b1) br_seen = branch_addr;
      ev_seen <= ev;
      if (ack === 1'b1 && note_q.size() == 0) check(32'h1, 32'h0, "extra answer");
      else if (ack === 1'b1) begin
        ev_seen <= 5'h0;
        got = note_q.pop_front();
        if (got.rchk) check(result, got.res, "result");
        check(32'(dut.flags & got.fm), 32'(got.flg & got.fm), "flags");
        check(base_out, got.base, "base");
        check(32'(ev[3:0]), 32'(got.ev[3:0]), "event");
        if (!got.ev[3]) check(32'(ev[4]), 32'(got.ev[4]), "branch");
        if (got.ev[4]) check(br_seen & ~32'h1, got.br & ~32'h1, "target");
        check(32'(privileged), 32'h1, "privilege");
      end
    end
  end

  // Every memory access must match the oldest expected one; an extra access fails.
  always @(posedge clock) begin
    if (rst_b && mem_req === 1'b1 && mem_ack === 1'b1) begin
      if (acc_q.size() == 0) check(32'h1, 32'h0, "extra access");
      else begin
        acc = acc_q.pop_front();
        check(mem_addr, acc.addr, "address");
        check(32'(mem_write), 32'(acc.wr), "direction");
        check(32'(mem_size), 32'(acc.sz), "size");
        if (acc.wr) check(mem_wdata, acc.wd, "store data");
      end
    end
  end

  // A hang is cut short well after the tests should have finished.
  initial begin
    repeat (30000) @(posedge clock);
    check(32'h0, 32'h1, "run timed out");
    conclude();
  end

  // Main sequence: reset, then the operation groups in turn.
  initial begin
    seed = 32'h972b4479;
    {req, sign_load, off_is_reg, off_reg_is_pc, off_sub, many_down, many_wb} = '0;
    {pop_loads_pc, debug_enable, priv_option, rst_b} = '0;
    {opa, opb, imm, shamt_imm, many_count, delay} = '0;
    op = IEX_COPY_IMM;
    size = IEX_SZ_WORD;
    base_sel = IEX_BASE_LOW;
    cur_base = 32'h0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    check(result, 32'h0, "reset result");
    check(32'(privileged), 32'h1, "reset privilege");
    for (int k = 0; k < 40; k++) begin
      r = xs();
      opa = r;
      opb = xs();
      go(IEX_WRITE_STATUS, nt(0, 0, r[31:28], 4'hf, 0));
      go(IEX_READ_STATUS, nt({r[31:28], 28'h0}, 1, 0, 0, 0));
      opa = opb;
      go(IEX_COPY_REG, nt(opb, 1, r[31:28], 4'hf, 0));
      cur_res = opb;
      o = iex_op_e'(6'(k % 20));
      opa = xs();
      opb = xs() & ((o inside {IEX_ASR_REG, IEX_LSL_REG, IEX_LSR_REG, IEX_ROR_REG})
                    ? 32'h1f : (o == IEX_RSB) ? 32'h0 : 32'hffff_ffff);
      imm = 8'(xs());
      shamt_imm = 5'(xs() % 31 + 1);
      r = alu(o, opa, opb, imm, shamt_imm);
      if (o == IEX_TEST) n = nt(cur_res, 1, {r[31], r == 0, 2'h0}, 4'hc, 0);
      else if (o == IEX_RSB)
        n = nt(r, 1, {r[31], r == 0, opa == 0, opa == 32'h8000_0000}, 4'hf, 0);
      else n = nt(r, 1, 0, 0, 0);
      go(o, n);
    end
    $display("alu test done");
    for (int i = 0; i < 24; i++) begin
      size = iex_size_e'(2'(i % 3));
      sign_load = 1'((i / 3) % 2);
      base_sel = (i % 2) ? IEX_BASE_STACK : IEX_BASE_LOW;
      opa = (xs() & 32'hffff_fffc) | 32'h8000_0000;
      imm = 8'(xs()) & 8'hfc;
      off_sub = 1'(xs());
      d = xs();
      opb = d;
      r = off_sub ? opa - imm : opa + imm;
      acc_q.push_back('{r, ext(d, size, 1'b0), 1'b1, size});
      go(IEX_STORE, nt(0, 0, 0, 0, 0));
      off_is_reg = (i % 4 == 0);
      opb = {24'h0, imm};
      acc_q.push_back('{r, 32'h0, 1'b0, size});
      go(IEX_LOAD, nt(ext(ext(d, size, 1'b0), size, sign_load), 1, 0, 0, 0));
      opa = xs() & 32'h0fff_ffff;
      base_sel = IEX_BASE_PC;
      off_is_reg = 1'b0;
      r = off_sub ? (opa & IEX_PC_ALIGN) - imm : (opa & IEX_PC_ALIGN) + imm;
      acc_q.push_back('{r, 32'h0, 1'b0, size});
      go(IEX_LOAD, nt(ext(r ^ 32'hc3a5_0011, size, sign_load), 1, 0, 0, 0));
    end
    go(IEX_STORE, nt(0, 0, 0, 0, 5'h01));
    base_sel = IEX_BASE_LOW;
    {off_is_reg, off_reg_is_pc} = 2'h3;
    go(IEX_STORE, nt(0, 0, 0, 0, 5'h01));
    {off_is_reg, off_reg_is_pc} = 2'h0;
    $display("load store test done");
    base_sel = IEX_BASE_STACK;
    for (int i = 0; i < 8; i++) begin
      c = 32'(i % 4 + 1);
      many_count = 5'(c);
      opa = (xs() & 32'h0fff_fff0) | 32'h4000_0000;
      opb = (xs() & 32'hffff_fffe) | 32'(i % 2);
      for (w = 0; w < c; w++) acc_q.push_back('{opa - 4 * c + 4 * w, opb, 1'b1, 2'h2});
      cur_base = opa - 4 * c;
      go(IEX_PUSH, nt(0, 0, 0, 0, 0));
      opa = cur_base;
      pop_loads_pc = 1'b1;
      for (w = 0; w < c; w++) acc_q.push_back('{opa + 4 * w, 32'h0, 1'b0, 2'h2});
      cur_base = opa + 4 * c;
      n = nt(0, 0, 0, 0, (i % 2) ? 5'h10 : 5'h08);
      n.br = opb;
      go(IEX_POP, n);
      pop_loads_pc = 1'b0;
      many_down = 1'((i / 2) % 2);
      many_wb = (i >= 4);
      o = (i % 2) ? IEX_STORE_MANY : IEX_LOAD_MANY;
      for (w = 0; w < c; w++)
        acc_q.push_back('{(many_down ? opa - 4 * c : opa) + 4 * w, opb, 1'(i % 2), 2'h2});
      if (many_wb) cur_base = many_down ? opa - 4 * c : opa + 4 * c;
      go(o, nt(0, 0, 0, 0, 0));
    end
    $display("multiple test done");
    for (int i = 0; i < 4; i++) begin
      debug_enable = 1'(i);
      go(IEX_SUPERVISOR_CALL, nt(0, 0, 0, 0, 5'h04));
      go(IEX_BREAKPOINT, nt(0, 0, 0, 0, debug_enable ? 5'h02 : 5'h00));
    end
    go(IEX_ILLEGAL, nt(0, 0, 0, 0, 5'h01));
    $display("exception test done");
    repeat (4) @(negedge clock);
    conclude();
  end
endmodule
`default_nettype wire
